// *** include/scp_pkg.sv ***
// Shared constants and types for the converter serial command port
package scp_pkg;

  // Command opcodes
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_RESET = 8'h06;
  localparam logic [7:0] OP_START = 8'h08;
  localparam logic [7:0] OP_STOP = 8'h0a;
  localparam logic [7:0] OP_RDATA = 8'h12;
  localparam logic [7:0] OP_OFS_CAL = 8'h16;
  localparam logic [7:0] OP_GAIN_CAL = 8'h17;
  localparam logic [7:0] OP_LOCK = 8'hf2;
  localparam logic [7:0] OP_UNLOCK = 8'hf5;
  localparam logic [7:0] OP_REGISTER_READ_CMD_BASE = 8'h20;
  localparam logic [7:0] OP_REGISTER_WRITE_CMD_BASE = 8'h40;
  localparam logic [7:0] OP_REG_MASK = 8'he0;
  localparam int REG_ADDR_W = 5;

  // Frame layout
  localparam logic [7:0] FIRST_OUT_BYTE = 8'hff;
  localparam logic [3:0] IDX_OPCODE = 4'h0;
  localparam logic [3:0] IDX_ARG = 4'h1;
  localparam logic [3:0] IDX_CRC_IN = 4'h2;
  localparam logic [3:0] IDX_CRC_OUT = 4'h3;
  localparam logic [3:0] LAST_PLAIN = 4'h3;
  localparam logic [3:0] LAST_REGISTER_READ_CMD = 4'h5;
  localparam logic [3:0] LAST_RDATA = 4'h7;
  localparam logic [3:0] LAST_RDATA_STAT = 4'h8;

  // Check byte engine: x^8+x^2+x+1 over a 40-bit ones-padded value
  localparam logic [8:0] CRC_POLY = 9'h107;
  localparam int CRC_VAL_W = 40;
  localparam logic [4:0] CRC_STEPS = 5'h14;

  // Conversion result
  localparam int RES_W = 24;
  localparam int RAW_W = 28;
  localparam logic [23:0] RES_MAX = 24'h7fffff;
  localparam logic [23:0] RES_MIN = 24'h800000;
  localparam int FIFO_DEPTH = 2;

  // Status byte bit positions
  localparam int STAT_READY_BIT = 6;
  localparam int STAT_CONV_ERR_BIT = 5;
  localparam int STAT_AMP_ERR_BIT = 4;
  localparam int STAT_AMP_SUM_BIT = 7;

  typedef enum logic [1:0] {
    SCP_F_CMD,
    SCP_F_PAY,
    SCP_F_DONE
  } scp_frame_e;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] arg;
    logic amp_section;
  } scp_cmd_s;

  typedef struct packed {
    logic sclk_m;
    logic sclk_s;
    logic sclk_p;
    logic din_m;
    logic din_s;
    logic cs1_m;
    logic cs1_s;
    logic cs2_m;
    logic cs2_s;
    scp_frame_e frame;
    logic [2:0] bit_idx;
    logic [3:0] byte_idx;
    logic [3:0] last_idx;
    logic [7:0] rx_sr;
    logic [7:0] op_q;
    logic [7:0] arg_q;
    logic [7:0] crc_cmd;
    logic crc_ok;
    logic rdata_rd;
    logic [7:0] tx_sr;
    logic sdo;
    logic data_mode;
    logic [39:0] eng_val;
    logic [4:0] eng_cnt;
    logic [7:0] eng_crc;
    logic [31:0] pay_sr;
    logic [23:0] result;
    logic new_data;
    logic ready_n;
    logic conv_err;
    logic amp_err;
    logic amp_sum;
    logic cmd_valid;
    scp_cmd_s cmd;
  } scp_state_s;

  localparam scp_state_s STATE_RST = '{
    frame: SCP_F_CMD,
    cs1_m: 1'b1,
    cs1_s: 1'b1,
    cs2_m: 1'b1,
    cs2_s: 1'b1,
    sdo: 1'b1,
    ready_n: 1'b1,
    default: '0
  };

endpackage

// *** verilog/scp_fifo2.sv ***
// Small valid/ready buffer between the result source and the serial port
`timescale 1ns/100ps
module scp_fifo2 #(
  parameter int WIDTH = scp_pkg::RES_W,
  parameter int DEPTH = scp_pkg::FIFO_DEPTH
) (
  // Clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } scp_fifo_s;

  scp_fifo_s st_q;
  scp_fifo_s st_d;
  logic push;
  logic pop;

  assign in_ready = (st_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_q.cnt != '0);
  assign out_data = st_q.mem[st_q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wp] = in_data;
      st_d.wp = st_q.wp + 1'b1;
    end
    if (pop) begin
      st_d.rp = st_q.rp + 1'b1;
    end
    // Pointers wrap naturally because the depth is a power of two
    st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

endmodule

// *** verilog/scp_port.sv ***
// Serial command port with check bytes, result readout and ready indication
`timescale 1ns/100ps
module scp_port (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Serial link pins
  input wire logic sclk,
  input wire logic din,
  input wire logic converter_select_n,
  input wire logic amplifier_select_n,
  output logic shared_out_ready_pin_o,
  output logic shared_out_ready_pin_oe_n,
  // Conversion core
  input wire logic conv_start,
  input wire logic pulse_mode,
  input wire logic raw_valid,
  output logic raw_ready,
  input wire logic [scp_pkg::RAW_W-1:0] raw_data,
  output logic result_ready_n,
  // Configuration and status
  input wire logic status_append_enable,
  input wire logic [7:0] status_base,
  output logic [7:0] status_byte_zero,
  input wire logic check_err_clear,
  output logic converter_check_error,
  output logic amplifier_check_error,
  output logic amplifier_status_summary,
  // Register file access
  output logic [scp_pkg::REG_ADDR_W-1:0] reg_rd_addr,
  input wire logic [7:0] reg_rd_data,
  // Executed commands
  output logic cmd_valid,
  output scp_pkg::scp_cmd_s cmd
);

  scp_pkg::scp_state_s st_q;
  scp_pkg::scp_state_s st_d;
  logic fifo_valid;
  logic fifo_pop;
  logic [scp_pkg::RES_W-1:0] fifo_data;
  logic [scp_pkg::RES_W-1:0] sat_data;

  // Two serial steps per clock of x^8+x^2+x+1
  function automatic logic [7:0] crc_step2(input logic [7:0] c, input logic [1:0] b);
    logic [7:0] r;
    r = {c[6:0], b[1]} ^ (c[7] ? scp_pkg::CRC_POLY[7:0] : 8'h00);
    r = {r[6:0], b[0]} ^ (r[7] ? scp_pkg::CRC_POLY[7:0] : 8'h00);
    return r;
  endfunction

  // Clip an oversized signed value into the 24-bit code range
  function automatic logic [23:0] sat24(input logic [scp_pkg::RAW_W-1:0] v);
    logic signed [scp_pkg::RAW_W-1:0] s;
    s = signed'(v);
    if (s > signed'(scp_pkg::RAW_W'(scp_pkg::RES_MAX))) begin
      return scp_pkg::RES_MAX;
    end else if (s < -signed'(scp_pkg::RAW_W'(scp_pkg::RES_MIN))) begin
      return scp_pkg::RES_MIN;
    end
    return v[23:0];
  endfunction

  // Status byte as seen by software, live flags overlaid on the base bits
  function automatic logic [7:0] status_of(input scp_pkg::scp_state_s s, input logic [7:0] b);
    logic [7:0] r;
    r = b;
    r[scp_pkg::STAT_READY_BIT] = s.new_data;
    r[scp_pkg::STAT_CONV_ERR_BIT] = s.conv_err;
    r[scp_pkg::STAT_AMP_ERR_BIT] = s.amp_err;
    r[scp_pkg::STAT_AMP_SUM_BIT] = s.amp_sum;
    return r;
  endfunction

  assign sat_data = sat24(raw_data);
  // A result readout in flight holds the buffer, so the source stalls
  assign fifo_pop = !(st_q.frame == scp_pkg::SCP_F_PAY && st_q.rdata_rd);

  scp_fifo2 #(
    .WIDTH(scp_pkg::RES_W),
    .DEPTH(scp_pkg::FIFO_DEPTH)
  ) u_buf (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .in_valid(raw_valid),
    .in_ready(raw_ready),
    .in_data(sat_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  always_comb begin
    logic active;
    logic amp;
    logic rise;
    logic fall;
    logic [7:0] rxb;
    logic [7:0] tx_next;
    logic [7:0] stat;
    st_d = st_q;
    active = 1'b0;
    amp = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    rxb = 8'h00;
    tx_next = 8'h00;
    stat = status_of(st_q, status_base);
    st_d.cmd_valid = 1'b0;

    // Pins pass two flops before any logic reads them
    st_d.sclk_m = sclk;
    st_d.sclk_s = st_q.sclk_m;
    st_d.sclk_p = st_q.sclk_s;
    st_d.din_m = din;
    st_d.din_s = st_q.din_m;
    st_d.cs1_m = converter_select_n;
    st_d.cs1_s = st_q.cs1_m;
    st_d.cs2_m = amplifier_select_n;
    st_d.cs2_s = st_q.cs2_m;
    active = !st_q.cs1_s || !st_q.cs2_s;
    amp = st_q.cs1_s && !st_q.cs2_s;
    rise = st_q.sclk_s && !st_q.sclk_p;
    fall = !st_q.sclk_s && st_q.sclk_p;

    // Error flags: a set in the clearing cycle wins
    if (check_err_clear) begin
      st_d.conv_err = 1'b0;
      st_d.amp_err = 1'b0;
      st_d.amp_sum = 1'b0;
    end

    // Conversion events drive the ready indication
    if (conv_start) begin
      st_d.ready_n = 1'b1;
    end
    if (fifo_valid && fifo_pop) begin
      st_d.result = fifo_data;
      st_d.new_data = 1'b1;
      st_d.ready_n = 1'b0;
    end

    // Check byte engine, runs over the padded value two bits a clock
    if (st_q.eng_cnt != '0) begin
      st_d.eng_crc = crc_step2(st_q.eng_crc, st_q.eng_val[39:38]);
      st_d.eng_val = {st_q.eng_val[37:0], 2'b11};
      st_d.eng_cnt = st_q.eng_cnt - 5'h01;
    end

    // Byte that goes out next, chosen at the first rising edge of a byte
    case (st_q.byte_idx)
      scp_pkg::IDX_OPCODE: tx_next = scp_pkg::FIRST_OUT_BYTE;
      scp_pkg::IDX_ARG: tx_next = st_q.op_q;
      scp_pkg::IDX_CRC_IN: tx_next = st_q.arg_q;
      scp_pkg::IDX_CRC_OUT: tx_next = st_q.crc_ok ? st_q.crc_cmd : ~st_q.crc_cmd;
      default: begin
        if (st_q.byte_idx == st_q.last_idx) begin
          tx_next = st_q.eng_crc;
        end else begin
          tx_next = st_q.pay_sr[31:24];
        end
      end
    endcase

    if (!active) begin
      // Deselect drops any half-done frame
      st_d.frame = scp_pkg::SCP_F_CMD;
      st_d.bit_idx = 3'h0;
      st_d.byte_idx = 4'h0;
      st_d.data_mode = 1'b0;
      st_d.sdo = 1'b1;
    end else if (st_q.frame != scp_pkg::SCP_F_DONE) begin
      if (rise) begin
        st_d.data_mode = 1'b1;
        if (st_q.bit_idx == 3'h0) begin
          st_d.sdo = tx_next[7];
          st_d.tx_sr = {tx_next[6:0], 1'b1};
          if (st_q.byte_idx > scp_pkg::IDX_CRC_OUT && st_q.byte_idx != st_q.last_idx) begin
            st_d.pay_sr = {st_q.pay_sr[23:0], 8'h00};
          end
        end else begin
          st_d.sdo = st_q.tx_sr[7];
          st_d.tx_sr = {st_q.tx_sr[6:0], 1'b1};
        end
      end
      if (fall) begin
        rxb = {st_q.rx_sr[6:0], st_q.din_s};
        st_d.rx_sr = rxb;
        st_d.bit_idx = st_q.bit_idx + 3'h1;
        if (st_q.bit_idx == 3'h7) begin
          st_d.byte_idx = st_q.byte_idx + 4'h1;
          case (st_q.byte_idx)
            scp_pkg::IDX_OPCODE: begin
              st_d.op_q = rxb;
            end
            scp_pkg::IDX_ARG: begin
              st_d.arg_q = rxb;
              // Opcode and second byte, ones-padded to 40 bits
              st_d.eng_val = {st_q.op_q, rxb, 24'hffffff};
              st_d.eng_cnt = scp_pkg::CRC_STEPS;
              st_d.eng_crc = 8'h00;
            end
            scp_pkg::IDX_CRC_IN: begin
              st_d.crc_cmd = st_q.eng_crc;
              st_d.crc_ok = (rxb == st_q.eng_crc);
            end
            scp_pkg::IDX_CRC_OUT: begin
              // Last clock of the fourth byte: the command takes effect here
              st_d.frame = scp_pkg::SCP_F_DONE;
              st_d.last_idx = scp_pkg::LAST_PLAIN;
              st_d.rdata_rd = 1'b0;
              st_d.data_mode = 1'b0;
              if (!st_q.crc_ok) begin
                if (amp) begin
                  st_d.amp_err = 1'b1;
                  st_d.amp_sum = 1'b1;
                end else begin
                  st_d.conv_err = 1'b1;
                end
              end else begin
                st_d.cmd_valid = (st_q.op_q != scp_pkg::OP_NOP);
                st_d.cmd = '{opcode: st_q.op_q, arg: st_q.arg_q, amp_section: amp};
                st_d.eng_crc = 8'h00;
                st_d.eng_cnt = scp_pkg::CRC_STEPS;
                if ((st_q.op_q & scp_pkg::OP_REG_MASK) == scp_pkg::OP_REGISTER_READ_CMD_BASE) begin
                  st_d.frame = scp_pkg::SCP_F_PAY;
                  st_d.data_mode = 1'b1;
                  st_d.last_idx = scp_pkg::LAST_REGISTER_READ_CMD;
                  st_d.pay_sr = {reg_rd_data, 24'h000000};
                  st_d.eng_val = {reg_rd_data, 32'hffffffff};
                end else if (st_q.op_q == scp_pkg::OP_RDATA) begin
                  st_d.frame = scp_pkg::SCP_F_PAY;
                  st_d.data_mode = 1'b1;
                  st_d.rdata_rd = 1'b1;
                  st_d.new_data = 1'b0;
                  if (!pulse_mode) begin
                    st_d.ready_n = 1'b1;
                  end
                  if (status_append_enable) begin
                    st_d.last_idx = scp_pkg::LAST_RDATA_STAT;
                    st_d.pay_sr = {stat, st_q.result};
                    st_d.eng_val = {stat, st_q.result, 8'hff};
                  end else begin
                    st_d.last_idx = scp_pkg::LAST_RDATA;
                    st_d.pay_sr = {st_q.result, 8'h00};
                    st_d.eng_val = {st_q.result, 16'hffff};
                  end
                end
              end
            end
            default: begin
              if (st_q.byte_idx == st_q.last_idx) begin
                st_d.frame = scp_pkg::SCP_F_DONE;
                st_d.data_mode = 1'b0;
                st_d.rdata_rd = 1'b0;
              end
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= scp_pkg::STATE_RST;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // Shared pin: data while a frame is shifting, else ready on converter select
  always_comb begin
    shared_out_ready_pin_oe_n = st_q.cs1_s && st_q.cs2_s;
    if (st_q.data_mode) begin
      shared_out_ready_pin_o = st_q.sdo;
    end else if (!st_q.cs1_s) begin
      shared_out_ready_pin_o = st_q.ready_n;
    end else begin
      shared_out_ready_pin_o = 1'b1;
    end
  end

  assign result_ready_n = st_q.ready_n;
  assign status_byte_zero = status_of(st_q, status_base);
  assign converter_check_error = st_q.conv_err;
  assign amplifier_check_error = st_q.amp_err;
  assign amplifier_status_summary = st_q.amp_sum;
  assign reg_rd_addr = st_q.op_q[scp_pkg::REG_ADDR_W-1:0];
  assign cmd_valid = st_q.cmd_valid;
  assign cmd = st_q.cmd;

endmodule

// *** verification/scp_port_props.sv ***
// Pin-level checks for the serial command port
`timescale 1ns/100ps
module scp_port_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link pins
  input wire logic sclk,
  input wire logic converter_select_n,
  input wire logic amplifier_select_n,
  input wire logic shared_out_ready_pin_o,
  input wire logic shared_out_ready_pin_oe_n,
  // Core, flags and commands
  input wire logic conv_start,
  input wire logic pulse_mode,
  input wire logic result_ready_n,
  input wire logic converter_check_error,
  input wire logic amplifier_check_error,
  input wire logic amplifier_status_summary,
  input wire logic cmd_valid,
  input wire scp_pkg::scp_cmd_s cmd
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Four samples cover the two-flop select sync with one to spare; the pin enable is decoded from the synced selects, not registered
  sequence s_idle;
    (converter_select_n && amplifier_select_n) [*4];
  endsequence
  sequence s_open;
    $fell(converter_select_n) ##1 (!converter_select_n && !sclk) [*5];
  endsequence
  property p_float_idle; s_idle |-> shared_out_ready_pin_oe_n; endproperty
  property p_drive_sel; (!converter_select_n) [*4] |-> !shared_out_ready_pin_oe_n; endproperty
  property p_ready_shown; s_open |-> shared_out_ready_pin_o == result_ready_n; endproperty
  property p_cmd_pulse; cmd_valid |=> !cmd_valid; endproperty
  property p_nop_quiet; cmd_valid |-> cmd.opcode != scp_pkg::OP_NOP; endproperty
  property p_conv_no_exec; $rose(converter_check_error) |-> !cmd_valid ##1 !cmd_valid; endproperty
  property p_amp_flags;
    $rose(amplifier_check_error) |-> amplifier_status_summary && !cmd_valid;
  endproperty
  property p_pulse_start; pulse_mode && conv_start |=> result_ready_n; endproperty
  property p_pulse_hold;
    pulse_mode && !conv_start && !result_ready_n |=> !result_ready_n;
  endproperty
  a_float_idle: assert property (p_float_idle)
    else $error("pin driven while deselected");
  a_drive_sel: assert property (p_drive_sel)
    else $error("pin not driven while selected");
  a_ready_shown: assert property (p_ready_shown)
    else $error("pin not showing ready at frame start");
  a_cmd_pulse: assert property (p_cmd_pulse)
    else $error("command strobe longer than one cycle");
  a_nop_quiet: assert property (p_nop_quiet)
    else $error("no-op executed");
  a_conv_no_exec: assert property (p_conv_no_exec)
    else $error("command executed on check failure");
  a_amp_flags: assert property (p_amp_flags)
    else $error("amplifier summary missing");
  a_pulse_start: assert property (p_pulse_start)
    else $error("ready not raised at conversion start");
  a_pulse_hold: assert property (p_pulse_hold)
    else $error("ready not held low in pulse mode");
endmodule
bind scp_port scp_port_props u_props (.clk(clk), .rst(rst), .sclk(sclk),
  .converter_select_n(converter_select_n), .amplifier_select_n(amplifier_select_n),
  .shared_out_ready_pin_o(shared_out_ready_pin_o),
  .shared_out_ready_pin_oe_n(shared_out_ready_pin_oe_n),
  .conv_start(conv_start), .pulse_mode(pulse_mode), .result_ready_n(result_ready_n),
  .converter_check_error(converter_check_error),
  .amplifier_check_error(amplifier_check_error),
  .amplifier_status_summary(amplifier_status_summary), .cmd_valid(cmd_valid), .cmd(cmd));

// *** verification/scp_host_model.sv ***
// Host controller model driving mode-1 frames on two selects
`timescale 1ns/100ps
module scp_host_model (
  // Clock
  input wire logic clk,
  // Link pins
  output logic sclk = 1'h0,
  output logic din = 1'h1,
  output logic converter_select_n = 1'h1,
  output logic amplifier_select_n = 1'h1,
  input wire logic pin_o,
  input wire logic pin_oe_n
);
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Gap after each byte leaves the serial check engine time to finish
  task automatic frame(input logic amp, input int n, input logic [7:0] tx [9],
                       output logic [7:0] rx [9]);
    wt(1);
    if (amp) amplifier_select_n = 1'h0;
    else converter_select_n = 1'h0;
    wt(8);
    for (int i = 0; i < n; i++) begin
      for (int b = 7; b >= 0; b--) begin
        sclk = 1'h1;
        din = tx[i][b];
        wt(4);
        // Take the bit at the falling edge, before the port retires the byte
        rx[i][b] = pin_oe_n ? 1'bx : pin_o;
        sclk = 1'h0;
        wt(4);
      end
      din = ~din;
      wt(24);
    end
    converter_select_n = 1'h1;
    amplifier_select_n = 1'h1;
    wt(8);
  endtask
endmodule

// *** verification/scp_port_tb.sv ***
// Self-checking bench for the serial command port
`timescale 1ns/100ps
module scp_port_tb;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic ce = 1'h1;
  logic conv_start = 1'h0;
  logic pulse_mode = 1'h0;
  logic raw_valid = 1'h0;
  logic [27:0] raw_data = 28'h0;
  logic stat_en = 1'h0;
  logic [7:0] stat_base = 8'h0a;
  logic err_clr = 1'h0;
  logic saw_full = 1'h0;
  logic sclk, din, cs1_n, cs2_n, pin_o, pin_oe_n, raw_ready, rdy_n, cmd_valid;
  logic conv_err, amp_err, amp_sum;
  logic [4:0] rd_addr;
  logic [7:0] stat0;
  logic [7:0] tx [9];
  logic [7:0] rx [9];
  scp_pkg::scp_cmd_s cmd, last_cmd;
  int err_total = 0;
  int total_checks = 0;
  int cmd_seen = 0;
  logic [7:0] ops [8] = '{8'h06, 8'h08, 8'h0a, 8'h16, 8'h17, 8'hf2, 8'hf5, 8'h42};
  logic [27:0] raws [6] = '{28'h0800000, 28'hf7fffff, 28'hfffffff, 28'h1, 28'h0, 28'h0123456};
  logic [23:0] sats [6] = '{24'h7fffff, 24'h800000, 24'hffffff, 24'h1, 24'h0, 24'h123456};

  scp_port dut (.clk(clk), .rst(rst), .ce(ce), .sclk(sclk), .din(din),
    .converter_select_n(cs1_n), .amplifier_select_n(cs2_n),
    .shared_out_ready_pin_o(pin_o), .shared_out_ready_pin_oe_n(pin_oe_n),
    .conv_start(conv_start), .pulse_mode(pulse_mode), .raw_valid(raw_valid),
    .raw_ready(raw_ready), .raw_data(raw_data), .result_ready_n(rdy_n),
    .status_append_enable(stat_en), .status_base(stat_base), .status_byte_zero(stat0),
    .check_err_clear(err_clr), .converter_check_error(conv_err),
    .amplifier_check_error(amp_err), .amplifier_status_summary(amp_sum),
    .reg_rd_addr(rd_addr), .reg_rd_data(8'hc0 ^ {3'h0, rd_addr}), .cmd_valid(cmd_valid),
    .cmd(cmd));
  scp_host_model host (.clk(clk), .sclk(sclk), .din(din), .converter_select_n(cs1_n),
    .amplifier_select_n(cs2_n), .pin_o(pin_o), .pin_oe_n(pin_oe_n));

  initial forever #4 clk = ~clk;

  always @(posedge clk) begin
    if (cmd_valid === 1'h1) begin
      cmd_seen <= cmd_seen + 1;
      last_cmd <= cmd;
    end
    if (raw_valid && raw_ready === 1'h0) saw_full <= 1'h1;
  end

  task automatic chk(input string nm, input logic [23:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [7:0] crc8(input logic [31:0] a, input int n);
    logic [39:0] v;
    v = ({8'h00, a} << (40 - 8 * n)) | ((40'h1 << (40 - 8 * n)) - 40'h1);
    for (int i = 39; i >= 8; i--) begin
      if (v[i]) v = v ^ ({31'h0, scp_pkg::CRC_POLY} << (i - 8));
    end
    return v[7:0];
  endfunction

  task automatic cmd_frame(input logic amp, input logic [7:0] op, arg, input logic bad,
                           input int n);
    logic [7:0] c;
    c = crc8({16'h0, op, arg}, 2);
    tx = '{default: 8'h00};
    tx[0] = op;
    tx[1] = arg;
    tx[2] = c ^ {8{bad}};
    host.frame(amp, n, tx, rx);
    chk("lead", 24'hff, rx[0]);
    chk("echo_op", op, rx[1]);
    chk("echo_arg", arg, rx[2]);
    if (n > 3) chk("crc_out", c ^ {8{bad}}, rx[3]);
  endtask

  task automatic rd_result(input logic [23:0] d, input logic se, input logic [7:0] st);
    int p;
    p = se ? 5 : 4;
    cmd_frame(1'h0, 8'h12, 8'h00, 1'h0, p + 4);
    if (se) chk("status", st, rx[4]);
    chk("result", d, {rx[p], rx[p + 1], rx[p + 2]});
    chk("res_crc", se ? crc8({st, d}, 4) : crc8({8'h00, d}, 3), rx[p + 3]);
  endtask

  task automatic push(input logic [27:0] d);
    raw_data = d;
    raw_valid = 1'h1;
    host.wt(1);
    raw_valid = 1'h0;
    host.wt(4);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #400000;
    err_total++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst = 1'h0;
    host.wt(4);
    cmd_frame(1'h0, 8'h00, 8'h3c, 1'h0, 4);
    chk("nop_cmds", 24'h0, 24'(cmd_seen));
    foreach (ops[k]) begin
      cmd_frame(1'h0, ops[k], 8'h5a ^ 8'(k), 1'h0, 4);
      chk("cmd", {ops[k], 8'h5a ^ 8'(k), 1'h0}, last_cmd);
    end
    cmd_frame(1'h0, 8'h08, 8'h11, 1'h0, 3);
    cmd_frame(1'h0, 8'h08, 8'h11, 1'h1, 4);
    cmd_frame(1'h1, 8'h32, 8'h00, 1'h1, 4);
    chk("err_flags", 24'h7, {conv_err, amp_err, amp_sum});
    chk("cmd_count", 24'h8, 24'(cmd_seen));
    err_clr = 1'h1;
    host.wt(1);
    err_clr = 1'h0;
    chk("flags_clr", 24'h0, {conv_err, amp_err, amp_sum});
    stat_base = 8'hf3;
    host.wt(1);
    chk("stat_base", 24'h03, stat0);
    stat_base = 8'h0a;
    ce = 1'h0;
    push(28'h0000077);
    ce = 1'h1;
    chk("ce_freeze", 24'h1, {stat0[6], rdy_n});
    cmd_frame(1'h0, 8'h0a, 8'h01, 1'h0, 4);
    chk("after_err", {8'h0a, 8'h01, 1'h0}, last_cmd);
    cmd_frame(1'h1, 8'h52, 8'h9c, 1'h0, 4);
    chk("amp_cmd", {8'h52, 8'h9c, 1'h1}, last_cmd);
    cmd_frame(1'h0, 8'h25, 8'h77, 1'h0, 6);
    chk("reg_data", 24'hc5, rx[4]);
    chk("reg_crc", crc8(32'hc5, 1), rx[5]);
    foreach (raws[k]) begin
      stat_en = k[0];
      push(raws[k]);
      chk("new_flag", 24'h2, {stat0[6], rdy_n});
      rd_result(sats[k], k[0], 8'h4a);
      chk("read_flag", 24'h1, {stat0[6], rdy_n});
    end
    rd_result(24'h123456, 1'h1, 8'h0a);
    pulse_mode = 1'h1;
    stat_en = 1'h0;
    push(28'h0000042);
    chk("pulse_result", 24'h0, rdy_n);
    conv_start = 1'h1;
    host.wt(1);
    conv_start = 1'h0;
    host.wt(1);
    chk("pulse_start", 24'h1, rdy_n);
    // Read stalls the buffer drain, so held pushes must be refused
    fork
      rd_result(24'h000042, 1'h0, 8'h00);
      begin
        host.wt(40);
        raw_data = 28'h0000042;
        raw_valid = 1'h1;
        host.wt(600);
        raw_valid = 1'h0;
      end
    join
    host.wt(4);
    chk("fill_drain", 24'h6, {saw_full, raw_ready, rdy_n});
    tally_and_finish();
  end
endmodule
